//--- hw/cpu_bus_master.sv
// External CPU end: turns user commands into paced bus strobes
`timescale 1ns/100ps
module cpu_bus_master
  import host_buf_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  SYS_RST,
  input  wire logic                  CE,
  host_buf_if.cpu_end                BUS,
  input  wire logic                  CMD_VALID,
  input  wire logic                  CMD_WRITE,
  input  wire logic [CPU_ADDR_W-1:0] CMD_ADDR,
  input  wire logic [CPU_DATA_W-1:0] CMD_WDATA,
  output logic                       CMD_READY,
  output logic                       RSP_VALID,
  output logic [CPU_DATA_W-1:0]      RSP_DATA,
  output logic                       IRQ
);

  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_ACCESS, ST_WAIT} mst_state_t;

  mst_state_t            state_reg;
  logic                  is_wr_reg;
  logic [CPU_ADDR_W-1:0] addr_reg;
  logic [CPU_DATA_W-1:0] wdata_reg;
  logic [CPU_ADDR_W-1:0] next_rd_reg;   // Address the device will prefetch next
  logic                  ptr_ok_reg;    // next_rd_reg is known to the device
  logic [2:0]            gap_reg;
  logic                  rd_pend_reg;
  logic                  cs_reg;
  logic                  we_reg;
  logic [CPU_ADDR_W-1:0] baddr_reg;
  logic [CPU_DATA_W-1:0] bwdata_reg;

  assign BUS.cs    = cs_reg;
  assign BUS.we    = we_reg;
  assign BUS.addr  = baddr_reg;
  assign BUS.wdata = bwdata_reg;

  // ==========================================================================
  // Command sequencer; memory reads reload the pointer only when out of sequence
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg   <= ST_IDLE;
      is_wr_reg   <= 1'b0;
      addr_reg    <= 16'h0000;
      wdata_reg   <= 32'h0000_0000;
      next_rd_reg <= 16'h0000;
      ptr_ok_reg  <= 1'b0;
      gap_reg     <= 3'h0;
      CMD_READY   <= 1'b0;
      cs_reg      <= 1'b0;
      we_reg      <= 1'b0;
      baddr_reg   <= 16'h0000;
      bwdata_reg  <= 32'h0000_0000;
    end else if (CE) begin
      cs_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            is_wr_reg <= CMD_WRITE;
            addr_reg  <= {CMD_ADDR[15:2], 2'b00};  // R10
            wdata_reg <= CMD_WDATA;
            if (!CMD_WRITE && CMD_ADDR >= BUF_BASE &&
                (!ptr_ok_reg || {CMD_ADDR[15:2], 2'b00} != next_rd_reg)) begin
              state_reg <= ST_PTR;
            end else begin
              state_reg <= ST_ACCESS;
            end
          end
        end
        ST_PTR: begin
          // Pointer must be loaded before reading buffer memory
          cs_reg      <= 1'b1;                                 // R16
          we_reg      <= 1'b1;
          baddr_reg   <= READ_PTR_OFS;
          bwdata_reg  <= {16'h0000, addr_reg};
          next_rd_reg <= addr_reg;
          ptr_ok_reg  <= 1'b1;
          gap_reg     <= 3'(BUS_GAP - 1);
          state_reg   <= ST_WAIT;
          is_wr_reg   <= 1'b0;
        end
        ST_ACCESS: begin
          // Buffer contents are written by this end and by the core port; the device never masters
          cs_reg     <= 1'b1;                                  // R11
          we_reg     <= is_wr_reg;
          baddr_reg  <= addr_reg;
          bwdata_reg <= wdata_reg;
          if (!is_wr_reg && addr_reg >= BUF_BASE) begin
            next_rd_reg <= next_rd_reg + DWORD_STEP;
          end
          if (is_wr_reg && addr_reg == READ_PTR_OFS) begin
            next_rd_reg <= {wdata_reg[15:2], 2'b00};
            ptr_ok_reg  <= 1'b1;
          end
          gap_reg   <= 3'(BUS_GAP - 1);
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (gap_reg != 3'h0) begin
            gap_reg <= gap_reg - 3'h1;
          end else if (baddr_reg == READ_PTR_OFS && we_reg && addr_reg != READ_PTR_OFS) begin
            state_reg <= ST_ACCESS;   // Pointer loaded, now the real read
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Read data is taken in the cycle after the read strobe
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_pend_reg <= 1'b0;
      RSP_VALID   <= 1'b0;
      RSP_DATA    <= 32'h0000_0000;
    end else if (CE) begin
      rd_pend_reg <= cs_reg && !we_reg;
      RSP_VALID   <= rd_pend_reg;
      if (rd_pend_reg) begin
        RSP_DATA <= BUS.rdata;
      end
    end
  end

  // Same clock as the device, so one register suffices
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= BUS.irq;
    end
  end

endmodule // cpu_bus_master

//--- hw/host_buf_mem.sv
// Host controller buffer memory: map, address translation, arbiter, prefetch
// Contract
// R1 - 63 kB buffer above a 1 kB register region
// R2 - Descriptor areas iso, int, async at 0400h-0FFFh
// R3 - Payload area 1000h to FFFFh, 60 kB
// R4 - Word address is (cpu address minus 0400h)>>3
// R5 - Word ranges per area as mapped
// R6 - Up to 32 descriptors per transfer type
// R7 - Every descriptor is eight double words
// R8 - Software clears descriptor reserved bits
// R9 - Software sizes payload to transfer length
// R10 - All buffer accesses are double word aligned
// R11 - CPU writes all contents; device never masters (the core also writes RAM words through HC_WE)
// R12 - Completion interrupt follows any and all masks
// R13 - Arbiter shares 64-bit RAM at 240 MB/s
// R14 - CPU rewrites while core runs, no corruption
// R15 - No wait states; reads served from prefetch
// R16 - Software loads read pointer at 033Ch first
// R17 - Simultaneous requests alternate, nobody starves
// R18 - Addresses below 0400h go to registers only
`timescale 1ns/100ps
module host_buf_mem
  import host_buf_pkg::*;
#(
  parameter int WORDS = RAM_WORDS
)(
  input  wire logic                   CLK_SYS,
  input  wire logic                   SYS_RST,
  input  wire logic                   CE,
  host_buf_if.buf_end                 BUS,
  input  wire logic                   HC_REQ,
  input  wire logic                   HC_WE,
  input  wire logic                   HC_SEL_DESC,
  input  wire logic [1:0]             HC_TYPE,
  input  wire logic [4:0]             HC_SLOT,
  input  wire logic [WORD_ADDR_W-1:0] HC_ADDR,
  input  wire logic [RAM_DATA_W-1:0]  HC_WDATA,
  output logic                        HC_GNT,
  output logic                        HC_RVALID,
  output logic [RAM_DATA_W-1:0]       HC_RDATA,
  input  wire logic [NUM_TYPES-1:0]   HC_DONE,
  input  wire logic [NUM_TYPES-1:0]   IRQ_CLR,
  input  wire logic [NUM_TYPES-1:0]   MASK_OR,
  input  wire logic [NUM_TYPES-1:0]   MASK_AND,
  output logic [NUM_TYPES-1:0]        DONE_STATUS,
  output logic                        REG_WR,
  output logic                        REG_RD,
  output logic [REG_ADDR_W-1:0]       REG_ADDR,
  output logic [CPU_DATA_W-1:0]       REG_WDATA,
  input  wire logic [CPU_DATA_W-1:0]  REG_RDATA
);

  // 64-bit wide buffer, word 0 sits at byte 0400h
  logic [RAM_DATA_W-1:0] mem [WORDS];                                   // R1 R13

  logic                  wr_pend_reg;
  logic [CPU_ADDR_W-1:0] wr_addr_reg;
  logic [CPU_DATA_W-1:0] wr_data_reg;
  logic [CPU_ADDR_W-1:0] rd_ptr_reg;
  logic                  pf_need_reg;
  logic [CPU_DATA_W-1:0] pf_data_reg;
  logic                  last_hc_reg;
  logic                  rdata_src_reg;
  logic [CPU_DATA_W-1:0] rdata_reg;
  logic [NUM_TYPES-1:0]  status_reg;
  logic                  irq_reg;

  logic                  cpu_wr;
  logic                  cpu_rd;
  logic                  hit_ptr;
  logic                  hit_reg;
  logic                  cpu_req;
  logic                  hc_ok;
  logic                  gnt_cpu;
  logic                  gnt_hc;
  logic [CPU_ADDR_W-1:0] cpu_byte;
  logic [WORD_ADDR_W-1:0] cpu_word;
  logic [WORD_ADDR_W-1:0] hc_word;
  logic [WORD_ADDR_W-1:0] area_base;

  // ==========================================================================
  // Byte address to RAM word: subtract the base, drop three bits
  function automatic logic [WORD_ADDR_W-1:0] to_word(input logic [CPU_ADDR_W-1:0] a);
    logic [CPU_ADDR_W-1:0] off;
    off = a - BUF_BASE;                                                   // R4
    return off[CPU_ADDR_W-1:WORD_SHIFT];                                  // R4 R5
  endfunction

  // ==========================================================================
  // Bus decode; the pointer is the one register this block owns
  assign cpu_wr  = BUS.cs && BUS.we;
  assign cpu_rd  = BUS.cs && !BUS.we;
  assign hit_ptr = BUS.addr[15:2] == READ_PTR_OFS[15:2];
  assign hit_reg = BUS.addr < BUF_BASE;                                   // R18

  // Core addresses a descriptor by type and slot, four RAM words each
  always_comb begin
    case (HC_TYPE)
      TT_ISO:  area_base = ISO_WBASE;                                     // R2 R5
      TT_INT:  area_base = INT_WBASE;
      TT_ASYNC: area_base = ASYNC_WBASE;
      default: area_base = PAYLOAD_WBASE;
    endcase
  end
  assign hc_word = HC_SEL_DESC ?
                   area_base + {6'h00, HC_SLOT, HC_ADDR[DESC_WORDS_LOG2-1:0]} : // R6 R7
                   HC_ADDR;                                               // R3

  // ==========================================================================
  // Arbiter: one RAM access per cycle, alternate on contention
  assign cpu_req  = wr_pend_reg || pf_need_reg;
  assign hc_ok    = HC_REQ && !HC_GNT;      // Request still held in the grant cycle
  assign gnt_cpu  = cpu_req && (!hc_ok || last_hc_reg);                   // R17
  assign gnt_hc   = hc_ok && !gnt_cpu;                                    // R17 R14
  assign cpu_byte = wr_pend_reg ? wr_addr_reg : rd_ptr_reg;
  assign cpu_word = to_word(cpu_byte);

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      last_hc_reg <= 1'b0;
      HC_GNT      <= 1'b0;
    end else if (CE) begin
      HC_GNT <= gnt_hc;
      if (gnt_cpu || gnt_hc) begin
        last_hc_reg <= gnt_hc;                                            // R17
      end
    end
  end

  // ==========================================================================
  // RAM port; a CPU write touches only its own half, so a core access to another
  // descriptor is never disturbed
  always_ff @(posedge CLK_SYS) begin
    if (CE) begin
      if (gnt_cpu && wr_pend_reg) begin
        if (cpu_byte[2]) begin                                            // R10 R14
          mem[cpu_word][63:32] <= wr_data_reg;
        end else begin
          mem[cpu_word][31:0] <= wr_data_reg;
        end
      end else if (gnt_hc && HC_WE) begin
        mem[hc_word] <= HC_WDATA;                                         // R14
      end
    end
  end

  // Read ports are registered so outputs come from flops
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      HC_RVALID   <= 1'b0;
      HC_RDATA    <= 64'h0000_0000_0000_0000;
      pf_data_reg <= 32'h0000_0000;
    end else if (CE) begin
      HC_RVALID <= gnt_hc && !HC_WE;
      if (gnt_hc && !HC_WE) begin
        HC_RDATA <= mem[hc_word];
      end
      if (gnt_cpu && !wr_pend_reg) begin
        pf_data_reg <= rd_ptr_reg[2] ? mem[cpu_word][63:32] : mem[cpu_word][31:0]; // R15
      end
    end
  end

  // ==========================================================================
  // CPU side: posted writes, pointer and prefetch; a new strobe wins over a clear
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 16'h0000;
      wr_data_reg <= 32'h0000_0000;
      rd_ptr_reg  <= BUF_BASE;
      pf_need_reg <= 1'b0;
    end else if (CE) begin
      if (gnt_cpu && wr_pend_reg) begin
        wr_pend_reg <= 1'b0;
      end else if (gnt_cpu) begin
        pf_need_reg <= 1'b0;
      end
      if (cpu_wr && hit_ptr) begin
        rd_ptr_reg  <= {BUS.wdata[15:2], 2'b00};                          // R16 R10
        pf_need_reg <= BUS.wdata[15:0] >= BUF_BASE;
      end else if (cpu_wr && !hit_reg) begin
        wr_pend_reg <= 1'b1;
        wr_addr_reg <= {BUS.addr[15:2], 2'b00};                           // R10
        wr_data_reg <= BUS.wdata;
      end
      if (cpu_rd && !hit_reg) begin
        rd_ptr_reg  <= rd_ptr_reg + DWORD_STEP;   // Address bus ignored, pointer walks
        pf_need_reg <= 1'b1;                                              // R15
      end
    end
  end

  // ==========================================================================
  // Read answer in the next cycle, never stretched
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg     <= 32'h0000_0000;
      rdata_src_reg <= 1'b0;
      REG_WR        <= 1'b0;
      REG_RD        <= 1'b0;
      REG_ADDR      <= 10'h000;
      REG_WDATA     <= 32'h0000_0000;
    end else if (CE) begin
      REG_WR <= cpu_wr && hit_reg && !hit_ptr;                            // R18
      REG_RD <= cpu_rd && hit_reg && !hit_ptr;
      if (BUS.cs && hit_reg) begin
        REG_ADDR  <= BUS.addr[REG_ADDR_W-1:0];
        REG_WDATA <= BUS.wdata;
      end
      if (cpu_rd) begin
        rdata_src_reg <= 1'b0;
        if (hit_ptr) begin
          rdata_reg <= {16'h0000, rd_ptr_reg};
        end else if (hit_reg) begin
          rdata_reg <= REG_RDATA;                                         // R18
        end else begin
          rdata_reg <= pf_data_reg;                                       // R15
        end
      end
    end
  end
  assign BUS.rdata = rdata_reg;

  // ==========================================================================
  // Completion flags; a done in the clear cycle stays set
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      status_reg <= '0;
      irq_reg    <= 1'b0;
    end else if (CE) begin
      status_reg <= (status_reg & ~IRQ_CLR) | HC_DONE;
      irq_reg    <= |(status_reg & MASK_OR) ||                            // R12
                    (MASK_AND != '0 && (status_reg & MASK_AND) == MASK_AND);
    end
  end
  assign BUS.irq     = irq_reg;
  assign DONE_STATUS = status_reg;

endmodule // host_buf_mem

//--- inc/host_buf_if.sv
// Parallel CPU bus between the external CPU end and the buffer memory end
`timescale 1ns/100ps
interface host_buf_if;
  import host_buf_pkg::*;

  logic                  cs;     // One-cycle access strobe
  logic                  we;     // Write when high, read when low
  logic [CPU_ADDR_W-1:0] addr;   // Byte address
  logic [CPU_DATA_W-1:0] wdata;
  logic [CPU_DATA_W-1:0] rdata;  // Valid from the cycle after a read strobe
  logic                  irq;    // Completion interrupt, level

  modport cpu_end (output cs, output we, output addr, output wdata, input rdata, input irq);
  modport buf_end (input cs, input we, input addr, input wdata, output rdata, output irq);
endinterface // host_buf_if

//--- inc/host_buf_pkg.sv
// Constants and types shared by both ends of the host buffer memory link
package host_buf_pkg;

  // ==========================================================================
  // Widths
  localparam int CPU_DATA_W  = 32;
  localparam int RAM_DATA_W  = 64;
  localparam int CPU_ADDR_W  = 16;
  localparam int WORD_ADDR_W = 13;
  localparam int REG_ADDR_W  = 10;

  // ==========================================================================
  // Address map, CPU byte addresses
  localparam logic [15:0] BUF_BASE     = 16'h0400;  // First byte above the register region
  localparam logic [15:0] ISO_BASE     = 16'h0400;
  localparam logic [15:0] INT_BASE     = 16'h0800;
  localparam logic [15:0] ASYNC_BASE   = 16'h0c00;
  localparam logic [15:0] PAYLOAD_BASE = 16'h1000;
  localparam logic [15:0] BUF_TOP      = 16'hffff;
  localparam logic [15:0] READ_PTR_OFS = 16'h033c;  // Read pointer in the register region
  localparam int          WORD_SHIFT   = 3;         // Byte address to 64-bit word index
  localparam logic [15:0] DWORD_STEP   = 16'h0004;

  // Word indexes of each area
  localparam logic [12:0] ISO_WBASE     = 13'h0000;
  localparam logic [12:0] INT_WBASE     = 13'h0080;
  localparam logic [12:0] ASYNC_WBASE   = 13'h0100;
  localparam logic [12:0] PAYLOAD_WBASE = 13'h0180;
  localparam int          RAM_WORDS     = 8192;

  // ==========================================================================
  // Descriptor geometry
  localparam int NUM_TYPES       = 3;
  localparam int DESC_PER_TYPE   = 32;
  localparam int DESC_DWORDS     = 8;
  localparam int DESC_WORDS_LOG2 = 2;   // Eight dwords fill four RAM words

  // ==========================================================================
  // Timing: cycles between two bus strobes, enough for one write and one prefetch
  localparam int BUS_GAP = 4;
  localparam int RAM_MBPS_MIN = 240;

  // Transfer types
  typedef enum logic [1:0] {
    TT_ISO,
    TT_INT,
    TT_ASYNC
  } xfer_type_t;

endpackage

//--- test/host_buf_assertions.sv
// Concurrent checks on the CPU bus that joins the two ends
`timescale 1ns/100ps
module host_buf_assertions
  import host_buf_pkg::*;
(
  input wire logic                  CLK_SYS,
  input wire logic                  SYS_RST,
  input wire logic                  cs,
  input wire logic                  we,
  input wire logic [CPU_ADDR_W-1:0] addr,
  input wire logic [CPU_DATA_W-1:0] wdata,
  input wire logic [CPU_DATA_W-1:0] rdata,
  input wire logic                  irq
);
  // ==========================================================================
  // Helper logic
  logic [2:0] gap_reg;
  logic       ptr_wr;
  logic       rd_strobe;

  // Cycles since the last strobe, saturating so the first strobe after reset passes
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      gap_reg <= 3'h7;
    end else if (cs) begin
      gap_reg <= 3'h0;
    end else if (gap_reg != 3'h7) begin
      gap_reg <= gap_reg + 3'h1;
    end
  end

  // Decoded strobes
  assign ptr_wr    = cs && we && (addr == READ_PTR_OFS);
  assign rd_strobe = cs && !we;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  AST_CS_ONE_CYCLE: assert property (cs |=> !cs)
    else $error("bus strobe longer than one cycle");
  AST_WRITE_GAP: assert property (cs && we |=> !cs [*3])
    else $error("strobe too soon after a write");
  AST_READ_GAP: assert property (rd_strobe |-> gap_reg >= 3'h3)
    else $error("read strobe too soon after the previous strobe");
  AST_DWORD_ALIGN: assert property (cs |-> addr[1:0] == 2'h0)
    else $error("bus address not double word aligned");
  AST_PTR_ALIGN: assert property (ptr_wr |-> wdata[1:0] == 2'h0 && wdata[31:16] == 16'h0)
    else $error("read pointer value malformed");
  AST_PTR_THEN_READ: assert property (ptr_wr |-> ##5 rd_strobe)
    else $error("pointer load not followed by its read");
  AST_RDATA_HOLDS: assert property (!rd_strobe |=> $stable(rdata))
    else $error("read data changed without a read strobe");
  AST_RDATA_CAUSE: assert property ($changed(rdata) |-> $past(rd_strobe))
    else $error("read data changed with no read one cycle earlier");

  // Main scenarios reached
  COV_PTR_LOAD: cover property (ptr_wr);
  COV_WRITE: cover property (cs && we && addr >= BUF_BASE);
  COV_READ: cover property (rd_strobe);
  COV_IRQ: cover property ($rose(irq));
endmodule // host_buf_assertions

//--- test/host_buf_memory_map_tb.sv
// Self-checking bench: CPU end and buffer memory end joined over the bus
`timescale 1ns/100ps
module host_buf_memory_map_tb;
  import host_buf_pkg::*;

  // Generous: the full sequence needs about a thousand cycles
  localparam int LIMIT = 40000;

  // ==========================================================================
  // Signals
  logic        clk_sys = 1'b0;
  logic        sys_rst, cmd_valid, cmd_write, cmd_ready, rsp_valid, irq_out;
  logic        hc_req, hc_we, hc_sel_desc, hc_gnt, hc_rvalid, reg_wr, reg_rd;
  logic [15:0] cmd_addr;
  logic [31:0] cmd_wdata, rsp_data, reg_rdata, reg_wdata, rd32, dval;
  logic [1:0]  hc_type;
  logic [4:0]  hc_slot;
  logic [12:0] hc_addr;
  logic [63:0] hc_wdata, hc_rdata, rd64;
  logic [2:0]  hc_done, irq_clr, mask_or, mask_and, done_status;
  logic [9:0]  reg_addr;
  logic [41:0] reg_wr_seen;
  logic [31:0] mem [int];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 11;
  int          cycles = 0;
  int          reg_wr_hits = 0;
  int          hits0, sl;

  always #10 clk_sys = ~clk_sys;

  // ==========================================================================
  // The two ends and the checker
  host_buf_if bus_if ();
  cpu_bus_master i_cpu_bus_master (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(1'b1), .BUS(bus_if.cpu_end),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .IRQ(irq_out));
  host_buf_mem i_host_buf_mem (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(1'b1), .BUS(bus_if.buf_end),
    .HC_REQ(hc_req), .HC_WE(hc_we), .HC_SEL_DESC(hc_sel_desc), .HC_TYPE(hc_type), .HC_SLOT(hc_slot),
    .HC_ADDR(hc_addr), .HC_WDATA(hc_wdata), .HC_GNT(hc_gnt), .HC_RVALID(hc_rvalid), .HC_RDATA(hc_rdata),
    .HC_DONE(hc_done), .IRQ_CLR(irq_clr), .MASK_OR(mask_or), .MASK_AND(mask_and),
    .DONE_STATUS(done_status), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));
  host_buf_assertions i_host_buf_assertions (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .cs(bus_if.cs),
    .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .irq(bus_if.irq));

  // ==========================================================================
  // Expectation helpers
  function automatic int desc_byte(int t, int s, int dw);
    return 32'h400 + t * 32'h400 + s * 32 + dw * 4;
  endfunction

  function automatic int word_byte(int w);
    return 32'h400 + w * 8;
  endfunction

  function automatic logic exp_irq(logic [2:0] st, logic [2:0] mo, logic [2:0] ma);
    return (|(st & mo)) || ((ma != 3'h0) && ((st & ma) == ma));
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // CPU end commands: held until taken, reads wait a bounded time for the answer
  task automatic cpu_op(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    check("command taken", {63'h0, n < 50}, 64'h1);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    q = rsp_data;
    if (!wr) check("read answer", {63'h0, rsp_valid}, 64'h1);
  endtask

  task automatic cpu_wr(input int a);
    dval = $random(seed);
    cpu_op(1'b1, 16'(a), dval, rd32);
    mem[a] = dval;
  endtask

  task automatic cpu_rd_chk(input int a);
    cpu_op(1'b0, 16'(a), 32'h0, rd32);
    check("cpu read data", {32'h0, rd32}, {32'h0, mem[a]});
  endtask

  // Core port: request held until the grant pulse is seen
  task automatic hc_op(input logic wr, input logic sel, input int t, input int s, input int a,
                       input logic [63:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    hc_req = 1'b1;
    hc_we = wr;
    hc_sel_desc = sel;
    hc_type = 2'(t);
    hc_slot = 5'(s);
    hc_addr = 13'(a);
    hc_wdata = d;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (hc_gnt !== 1'b1 && n < 20);
    rd64 = hc_rdata;
    if (!wr) check("core read valid", {63'h0, hc_rvalid}, 64'h1);
    check("core grant wait", {63'h0, n <= 4}, 64'h1);
    hc_req = 1'b0;
  endtask

  task automatic hc_wr(input int w);
    hc_op(1'b1, 1'b0, 0, 0, w, {$random(seed), $random(seed)});
    mem[word_byte(w)] = hc_wdata[31:0];
    mem[word_byte(w) + 4] = hc_wdata[63:32];
  endtask

  task automatic hc_rd_chk(input logic sel, input int t, input int s, input int a);
    int b;
    b = sel ? desc_byte(t, s, a * 2) : word_byte(a);
    hc_op(1'b0, sel, t, s, a, 64'h0);
    check("core read data", rd64, {mem[b + 4], mem[b]});
  endtask

  // ==========================================================================
  // Monitors: wire alignment, register forwarding, run limit
  always @(posedge clk_sys) begin
    if (bus_if.cs === 1'b1) check("bus address low bits", {62'h0, bus_if.addr[1:0]}, 64'h0);
    if ((reg_wr | reg_rd) === 1'b1) begin
      reg_wr_hits++;
      reg_wr_seen = {reg_addr, reg_wdata};
    end
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {sys_rst, cmd_valid, cmd_write, hc_req, hc_we, hc_sel_desc} = 6'h20;
    {cmd_addr, cmd_wdata, reg_rdata, hc_type, hc_slot, hc_addr, hc_wdata} = '0;
    {hc_done, irq_clr, mask_or, mask_and} = 12'h0;
    repeat (20) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check("status after reset", {61'h0, done_status}, 64'h0);
    // Descriptor areas: first, last and one random slot of every type, read back as words
    for (int t = 0; t < NUM_TYPES; t++) begin
      for (int k = 0; k < 3; k++) begin
        sl = (k == 0) ? 0 : (k == 1) ? 31 : 1 + $unsigned($random(seed)) % 30;
        for (int dw = 0; dw < DESC_DWORDS; dw++) cpu_wr(desc_byte(t, sl, dw));
        for (int w = 0; w < 4; w++) hc_rd_chk(1'b1, t, sl, w);
      end
    end
    // Payload ends and a random word, read in halves from the CPU side
    for (int k = 0; k < 3; k++) begin
      sl = (k == 0) ? 32'h180 : (k == 1) ? 32'h1f7f : 32'h180 + $unsigned($random(seed)) % 32'h1dff;
      hc_wr(sl);
      cpu_rd_chk(word_byte(sl));
      cpu_rd_chk(word_byte(sl) + 4);
    end
    // CPU rewrites one descriptor while the core walks another
    for (int dw = 0; dw < DESC_DWORDS; dw++) cpu_wr(desc_byte(1, 3, dw));
    fork
      for (int i = 0; i < 12; i++) cpu_wr(desc_byte(0, 5, i % 8));
      for (int i = 0; i < 12; i++) hc_rd_chk(1'b1, 1, 3, i % 4);
    join
    for (int w = 0; w < 4; w++) hc_rd_chk(1'b1, 0, 5, w);
    // Register region: forwarded, never aliased onto the word it would wrap to
    hc_wr(32'h1fc0);
    hits0 = reg_wr_hits;
    cpu_op(1'b1, 16'h0200, 32'h5a5a_0f0f, rd32);
    repeat (6) @(posedge clk_sys);
    check("register writes", 64'(reg_wr_hits - hits0), 64'h1);
    check("register write", {22'h0, reg_wr_seen}, {22'h0, 10'h200, 32'h5a5a_0f0f});
    hc_rd_chk(1'b0, 0, 0, 32'h1fc0);
    reg_rdata = $random(seed);
    hits0 = reg_wr_hits;
    cpu_op(1'b0, 16'h0100, 32'h0, rd32);
    check("register reads", 64'(reg_wr_hits - hits0), 64'h1);
    check("register read", {32'h0, rd32}, {32'h0, reg_rdata});
    // Completion interrupt: corner masks first, then random ones
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      irq_clr = 3'h7;
      mask_or = (i < 2) ? 3'h0 : 3'($random(seed));
      mask_and = (i < 2) ? 3'h7 : 3'($random(seed));
      @(posedge clk_sys);
      #1;
      irq_clr = 3'h0;
      hc_done = (i == 0) ? 3'h3 : (i == 1) ? 3'h7 : 3'($random(seed));
      dval = {29'h0, hc_done};
      @(posedge clk_sys);
      #1;
      hc_done = 3'h0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("done status", {61'h0, done_status}, {32'h0, dval});
      check("interrupt", {63'h0, irq_out}, {63'h0, exp_irq(dval[2:0], mask_or, mask_and)});
    end
    give_verdict();
  end
endmodule // host_buf_memory_map_tb
